// >>> eaf_assertions.sv
// Port checks for the aggregate formatter.
// Assumes a bind to the formatter; reset defaults give a 4-word size word.
`timescale 1ns/1ps
module eaf_assertions (
  input wire        clock,
  input wire        rstn,
  input wire [7:0]  address,
  input wire        read_strobe,
  input wire [31:0] read_data,
  input wire        saturated,
  input wire        sample_valid,
  input wire        sample_take,
  input wire [31:0] out_word,
  input wire        out_valid,
  input wire        out_ready
);
  // ----
  // Word position since reset
  // ----
  reg [1:0] words;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) words <= 2'd0;
    else if (out_valid && out_ready && words != 2'd2) words <= words + 2'd1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  read_idle_a: assert property (!$past(read_strobe) |-> read_data == 32'h0)
    else $error("read data outside its answer cycle");
  unmapped_zero_a: assert property ($past(read_strobe) && $past(address) == 8'h14
    |-> read_data == 32'h0) else $error("unmapped read not zero");
  word_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("stalled word changed");
  take_single_a: assert property (sample_take |=> !sample_take)
    else $error("sample take longer than one cycle");
  take_cause_a: assert property (sample_take |-> $past(sample_valid))
    else $error("sample taken without data");
  first_size_a: assert property (out_valid && words == 2'd0 |-> out_word == 32'h8000_0004)
    else $error("size word after reset wrong");
  first_format_a: assert property (out_valid && words == 2'd1 |-> out_word == 32'h7000_0000)
    else $error("format word after reset wrong");
  sat_event_a: assert property ($rose(saturated) |-> ##[1:300] (out_valid && out_word[15:0] == 16'hFFFF))
    else $error("no saturation event");
endmodule

// >>> event_aggregate_formatter.v
// Channel aggregate formatter: packs events into 32-bit words for readout.
// Assumes event, sample, saturation and memory-full inputs share the clock;
// only the external stamp clear arrives from a pin.
//
// Overview of operation
// [RULE1] Aggregate opens with size word; top bit flags a following format word.
// [RULE2] Format word flags dual trace, waveform, energy and stamp enables.
// [RULE3] Format word low bits hold sample count halved, the packed word count.
// [RULE4] Probe one select: 00 raw, 01 filter one, 10 filter two, 11 trapezoid.
// [RULE5] Probe two select: 00 raw, 01 threshold, 10 trap minus base, 11 base.
// [RULE6] Digital select 0000 unused, 0001 armed, 0010 peak run, 0011 pile-up, 0100 peaking.
// [RULE7] Digital 0101 window, 0110/0111 hold-offs, 1000 validation, 1001 veto.
// [RULE8] Event word top bit is trigger source, rest is time tag.
// [RULE9] Sample word: low half even probe one, high half odd one or probe two.
// [RULE10] Each half carries a trigger marker and the digital probe bit.
// [RULE11] Pile-up bit zero and energy zero, unless control bit 27 flags it.
// [RULE12] Extras bit 0 marks dead time before this event.
// [RULE13] Extras bit 1 marks a stamp wrap, bit 2 an external stamp clear.
// [RULE14] Bits 25 and 26 enable synthetic events for external clear and wrap.
// [RULE15] Saturation inhibits acquisition and stores one event, bit 15, max energy.
// [RULE16] After saturation triggers blocked twice decay time; next event has bit 16.
// [RULE17] Memory full drops events; first stored after has bit 16, normal energy.
// [RULE18] Each aggregate holds exactly the programmed event count back to back.
// [RULE19] Event order: time tag, sample words if enabled, then energy word.
// [RULE20] Host keeps events per aggregate at 1023 or less.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "event_aggregate_formatter_defines.vh"
module event_aggregate_formatter (
  input  wire        clock,
  input  wire        rstn,
  input  wire [7:0]  address,
  input  wire [31:0] write_data,
  input  wire        write_strobe,
  input  wire        read_strobe,
  output reg  [31:0] read_data,
  input  wire        event_valid,
  input  wire        event_external,
  input  wire [30:0] event_stamp,
  input  wire [14:0] event_energy,
  input  wire        event_pileup,
  input  wire        stamp_wrap,
  input  wire        general_input_pin,
  input  wire        saturated,
  input  wire        memory_full,
  input  wire        sample_valid,
  input  wire [13:0] probe_one_even,
  input  wire [13:0] probe_one_odd,
  input  wire [13:0] probe_two_even,
  input  wire        trigger_even,
  input  wire        trigger_odd,
  input  wire        digital_even,
  input  wire        digital_odd,
  output reg         sample_take,
  output reg  [31:0] out_word,
  output reg         out_valid,
  input  wire        out_ready
);
  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] ST_SIZE    = 3'd0;
  localparam [2:0] ST_FORMAT  = 3'd1;
  localparam [2:0] ST_WAIT    = 3'd2;
  localparam [2:0] ST_STAMP   = 3'd3;
  localparam [2:0] ST_SAMPLES = 3'd4;
  localparam [2:0] ST_ENERGY  = 3'd5;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [31:0] pulse_processing_control;
  reg  [31:0] format_config;
  reg  [9:0]  events_per_aggregate;
  reg  [15:0] decay_time;
  reg  [2:0]  state;
  reg  [9:0]  event_count;
  reg  [15:0] word_count;
  reg  [16:0] holdoff;
  reg         saturated_d;
  reg  [31:0] agg_format;
  reg  [9:0]  agg_events;
  reg         pin_level;
  reg         slot_full;
  reg         slot_external;
  reg  [30:0] slot_stamp;
  reg  [14:0] slot_energy;
  reg         slot_pileup;
  reg         slot_saturation;
  reg  [3:0]  slot_extras;
  reg         pin_s1;
  reg         pin_s2;
  reg         pin_s3;

  wire        format_word_present = pulse_processing_control[`CTRL_FORMAT_ON];
  // Layout is latched at the size word so an aggregate matches its own header
  wire        dual_trace_flag     = agg_format[`FMT_DUAL];
  wire        waveform_enable     = agg_format[`FMT_WAVE];
  wire [15:0] half_count          = agg_format[15:0];
  // Selector codes are carried verbatim into the format word
  wire [1:0]  analog_probe_one_select = format_config[23:22];  // see [RULE4]
  wire [1:0]  analog_probe_two_select = format_config[21:20];  // see [RULE5]
  wire [3:0]  digital_probe_select    = format_config[19:16];  // see [RULE6] see [RULE7]
  wire        can_load = !out_valid || out_ready;
  wire        stamp_external_clear = pin_s2 && pin_s3 && !pin_level;
  wire        flag_dead;
  wire        flag_wrap;
  wire        flag_clear;
  wire        take_flags;

  // --------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pulse_processing_control <= `RST_CONTROL;
      format_config            <= `RST_FORMAT;
      events_per_aggregate     <= `RST_EVENTS;
      decay_time               <= `RST_DECAY;
      read_data                <= 32'h0000_0000;
    end else begin
      if (write_strobe) begin
        case (address)
          `OFFS_CONTROL: pulse_processing_control <= write_data & `CTRL_MASK;
          `OFFS_FORMAT:  format_config <= write_data & `FMT_MASK;
          `OFFS_EVENTS:  events_per_aggregate <= write_data[9:0];  // see [RULE20]
          `OFFS_DECAY:   decay_time <= write_data[15:0];
          default: ;
        endcase
      end
      if (read_strobe) begin
        case (address)
          `OFFS_CONTROL: read_data <= pulse_processing_control;
          `OFFS_FORMAT:  read_data <= format_config;
          `OFFS_EVENTS:  read_data <= {22'h00_0000, events_per_aggregate};
          `OFFS_DECAY:   read_data <= {16'h0000, decay_time};
          `OFFS_STATUS:  read_data <= {10'h000, event_count, holdoff != 17'h0_0000,
                                       saturated_d, slot_full, flag_clear, flag_wrap,
                                       flag_dead, 3'h0, state};
          default:       read_data <= 32'h0000_0000;
        endcase
      end else begin
        read_data <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------
  // External clear pin synchroniser
  // --------------------------------------------------------------------
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      pin_s1 <= general_input_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      // A new level counts only once the last two stages agree
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
    end
  end

  // --------------------------------------------------------------------
  // Pending extras flags
  // --------------------------------------------------------------------
  wire sat_rise  = saturated && !saturated_d;
  wire sat_fall  = !saturated && saturated_d;
  wire blocked   = saturated || saturated_d || (holdoff != 17'h0_0000);
  wire drop_full = event_valid && memory_full;
  wire real_take = event_valid && !memory_full && !blocked && !slot_full;
  wire synth_ext  = stamp_external_clear && pulse_processing_control[`CTRL_SYNTH_EXT];
  wire synth_wrap = stamp_wrap && pulse_processing_control[`CTRL_SYNTH_WRAP];
  assign take_flags = !slot_full && (sat_rise || synth_ext || synth_wrap || real_take);
  // A synthetic event already reports the wrap or clear of its own cycle
  wire synth_take = take_flags && !sat_rise && (synth_ext || synth_wrap);

  sticky_flag u_flag_dead (
    .clock (clock),
    .rstn  (rstn),
    .set   (drop_full || sat_fall),  // see [RULE12]
    .clear (take_flags && !sat_rise),
    .flag  (flag_dead)
  );
  sticky_flag u_flag_wrap (
    .clock (clock),
    .rstn  (rstn),
    .set   (stamp_wrap && !synth_take),  // see [RULE13]
    .clear (take_flags),
    .flag  (flag_wrap)
  );
  sticky_flag u_flag_clear (
    .clock (clock),
    .rstn  (rstn),
    .set   (stamp_external_clear && !synth_take),  // see [RULE13]
    .clear (take_flags),
    .flag  (flag_clear)
  );

  // --------------------------------------------------------------------
  // Event capture slot and saturation hold-off
  // --------------------------------------------------------------------
  // One slot only: events arriving while it is occupied are lost, so the
  // readout side must drain faster than the trigger rate.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      saturated_d     <= 1'b0;
      holdoff         <= 17'h0_0000;
      slot_full       <= 1'b0;
      slot_external   <= 1'b0;
      slot_stamp      <= 31'h0000_0000;
      slot_energy     <= 15'h0000;
      slot_pileup     <= 1'b0;
      slot_saturation <= 1'b0;
      slot_extras     <= 4'h0;
    end else begin
      saturated_d <= saturated;
      if (sat_fall) begin
        holdoff <= {decay_time, 1'b0};  // see [RULE16]
      end else if (holdoff != 17'h0_0000) begin
        holdoff <= holdoff - 17'h0_0001;
      end
      if (state == ST_ENERGY && can_load) begin
        slot_full <= 1'b0;
      end else if (take_flags) begin
        slot_full       <= 1'b1;
        slot_external   <= event_external && real_take;
        slot_stamp      <= event_stamp;
        slot_pileup     <= event_pileup && real_take;
        slot_saturation <= sat_rise;
        if (sat_rise) begin
          // Store one marker event on entering saturation
          slot_energy <= `EN_MAX;  // see [RULE15]
          slot_extras <= {1'b0, flag_clear, flag_wrap, 1'b0};
        end else if (synth_ext || synth_wrap) begin
          slot_energy <= 15'h0000;
          slot_extras <= {1'b1, flag_clear | stamp_external_clear,
                          flag_wrap | stamp_wrap, flag_dead};  // see [RULE14]
        end else begin
          slot_energy <= event_energy;  // see [RULE17]
          slot_extras <= {1'b0, flag_clear, flag_wrap, flag_dead};  // see [RULE12] see [RULE13]
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Word sequencer
  // --------------------------------------------------------------------
  wire [15:0] event_words = format_config[`FMT_WAVE] ? (format_config[15:0] + 16'h0002) :
                            16'h0002;
  wire [30:0] agg_size = {21'h00_0000, events_per_aggregate} * {15'h0000, event_words}
                         + (format_word_present ? 31'h0000_0002 : 31'h0000_0001);
  wire        pu_mode = pulse_processing_control[`CTRL_PILEUP_MODE];
  wire [14:0] energy_out = (slot_pileup && !pu_mode) ? 15'h0000 : slot_energy;  // see [RULE11]
  wire        bit15_out = slot_saturation | (slot_pileup && pu_mode);  // see [RULE11]
  wire [15:0] upper_half = dual_trace_flag ?
                           {trigger_even, digital_even, probe_two_even} :
                           {trigger_odd, digital_odd, probe_one_odd};  // see [RULE9] see [RULE10]

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state       <= ST_SIZE;
      event_count <= 10'h000;
      word_count  <= 16'h0000;
      out_word    <= 32'h0000_0000;
      out_valid   <= 1'b0;
      sample_take <= 1'b0;
      agg_format  <= `RST_FORMAT;
      agg_events  <= `RST_EVENTS;
    end else begin
      sample_take <= 1'b0;
      if (out_valid && out_ready) begin
        out_valid <= 1'b0;
      end
      case (state)
        ST_SIZE: begin
          if (can_load && events_per_aggregate != 10'h000) begin
            out_word    <= {format_word_present, agg_size};  // see [RULE1]
            out_valid   <= 1'b1;
            event_count <= 10'h000;
            agg_format  <= format_config;
            agg_events  <= events_per_aggregate;
            state       <= format_word_present ? ST_FORMAT : ST_WAIT;
          end
        end
        ST_FORMAT: begin
          if (can_load) begin
            out_word  <= agg_format;  // see [RULE2] see [RULE3]
            out_valid <= 1'b1;
            state     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (slot_full) begin
            state <= ST_STAMP;
          end
        end
        ST_STAMP: begin
          if (can_load) begin
            out_word   <= {slot_external, slot_stamp};  // see [RULE8]
            out_valid  <= 1'b1;
            word_count <= 16'h0000;
            state      <= (waveform_enable && half_count != 16'h0000) ?
                          ST_SAMPLES : ST_ENERGY;  // see [RULE19]
          end
        end
        ST_SAMPLES: begin
          // Skip the cycle after a take so held sample data is not reused
          if (can_load && sample_valid && !sample_take) begin
            out_word    <= {upper_half, trigger_even, digital_even, probe_one_even};  // see [RULE9]
            out_valid   <= 1'b1;
            sample_take <= 1'b1;
            word_count  <= word_count + 16'h0001;
            if (word_count + 16'h0001 == half_count) begin
              state <= ST_ENERGY;
            end
          end
        end
        ST_ENERGY: begin
          if (can_load) begin
            out_word    <= {12'h000, slot_extras, bit15_out, energy_out};  // see [RULE19]
            out_valid   <= 1'b1;
            event_count <= event_count + 10'h001;
            if (event_count + 10'h001 == agg_events) begin
              state <= ST_SIZE;  // see [RULE18]
            end else begin
              state <= ST_WAIT;
            end
          end
        end
        default: begin
          state <= ST_SIZE;
        end
      endcase
    end
  end
endmodule

// >>> event_aggregate_formatter_defines.vh
// Offsets, field positions and reset values for the aggregate formatter.
// Assumes byte-addressed 8-bit register port with 32-bit data.
`ifndef EVENT_AGGREGATE_FORMATTER_DEFINES_VH
`define EVENT_AGGREGATE_FORMATTER_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFFS_CONTROL      8'h00
`define OFFS_FORMAT       8'h04
`define OFFS_EVENTS       8'h08
`define OFFS_DECAY        8'h0C
`define OFFS_STATUS       8'h10

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_FORMAT_ON    0
`define CTRL_SYNTH_EXT    25
`define CTRL_SYNTH_WRAP   26
`define CTRL_PILEUP_MODE  27
`define CTRL_MASK         32'h0E00_0001

// ----------------------------------------------------------------------
// Format word fields
// ----------------------------------------------------------------------
`define FMT_DUAL          31
`define FMT_WAVE          30
`define FMT_ENERGY        29
`define FMT_STAMP         28
`define FMT_MASK          32'hF0FF_FFFF

// ----------------------------------------------------------------------
// Data word fields
// ----------------------------------------------------------------------
`define WORD_TOP          31
`define HALF_TRIG         15
`define HALF_DIG          14
`define EN_SATURATED      15
`define EN_MAX            15'h7FFF
`define EX_DEAD           0
`define EX_WRAP           1
`define EX_CLEAR          2
`define EX_SYNTH          3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CONTROL       32'h0000_0001
`define RST_FORMAT        32'h7000_0000
`define RST_EVENTS        10'h001
`define RST_DECAY         16'h0000

`endif

// >>> event_aggregate_formatter_tb.sv
// Self-checking bench for the aggregate formatter.
// Assumes decay time is written small so holdoff stays short.
`timescale 1ns/1ps
`include "event_aggregate_formatter_defines.vh"
module event_aggregate_formatter_tb;
  reg         clock = 1'b0;
  reg         rstn, write_strobe, read_strobe, event_valid, event_external, event_pileup;
  reg         stamp_wrap, general_input_pin, saturated, memory_full, slow, rd_pend, pmode;
  reg  [7:0]  address;
  reg  [31:0] write_data, nfmt, fmt;
  reg  [30:0] event_stamp;
  reg  [14:0] event_energy;
  reg  [9:0]  nevt;
  reg  [31:0] smp [0:63];
  reg  [31:0] exp_q [$];
  reg  [31:0] rd_q [$];
  wire [31:0] read_data, out_word, word, cur;
  wire        sample_take, out_valid, out_ready, got;
  integer     seed, n_errors, samples_checked, cycles, didx, sidx, agg_left, k;
  assign cur = smp[didx];
  event_aggregate_formatter i_event_aggregate_formatter (.clock(clock), .rstn(rstn),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .event_valid(event_valid),
    .event_external(event_external), .event_stamp(event_stamp), .event_energy(event_energy),
    .event_pileup(event_pileup), .stamp_wrap(stamp_wrap), .general_input_pin(general_input_pin),
    .saturated(saturated), .memory_full(memory_full), .sample_valid(1'b1),
    .probe_one_even(cur[13:0]), .probe_one_odd(~cur[13:0]), .probe_two_even(cur[27:14]),
    .trigger_even(cur[28]), .trigger_odd(cur[30]), .digital_even(cur[29]),
    .digital_odd(cur[31]), .sample_take(sample_take), .out_word(out_word),
    .out_valid(out_valid), .out_ready(out_ready));
  host_reader i_host_reader (.clock(clock), .rstn(rstn), .out_word(out_word),
    .out_valid(out_valid), .slow(slow), .out_ready(out_ready), .got(got), .word(word));
  always #12.5 clock = ~clock;
  // ----
  // Watchers
  // ----
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      results;
    end
    if (sample_take) didx <= didx + 1;
    rd_pend <= read_strobe;
    if (rd_pend) check(read_data, rd_q.pop_front());
    if (got && exp_q.size() == 0) begin
      n_errors = n_errors + 1;
      $display("unexpected extra word at %0t", $time);
    end else if (got) check(word, exp_q.pop_front());
  end
  task check(input [31:0] seen, input [31:0] want);
    samples_checked = samples_checked + 1;
    if (seen !== want) begin
      n_errors = n_errors + 1;
      $display("unexpected value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task results;
    $display("compared %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clock);
    address <= a; write_data <= d; write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    rd_q.push_back(e);
    @(posedge clock);
    address <= a; read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
  endtask
  task header;
    reg [31:0] sz;
    sz = nevt * (32'd2 + (nfmt[30] ? nfmt[15:0] : 16'h0)) + 32'd2;
    exp_q.push_back({1'b1, sz[30:0]});
    exp_q.push_back(nfmt);
    fmt = nfmt;
    agg_left = nevt;
  endtask
  task push_ev(input [31:0] st, input [31:0] en);
    reg [31:0] s;
    exp_q.push_back(st);
    if (fmt[30]) for (k = 0; k < fmt[15:0]; k = k + 1) begin
      s = smp[sidx];
      sidx = sidx + 1;
      exp_q.push_back({fmt[31] ? {s[28], s[29], s[27:14]} : {s[30], s[31], ~s[13:0]},
                       s[28], s[29], s[13:0]});
    end
    exp_q.push_back(en);
    agg_left = agg_left - 1;
    if (agg_left == 0) header;
  endtask
  task drain;
    for (k = 0; k < 3000 && exp_q.size() != 0; k = k + 1) @(posedge clock);
    if (exp_q.size() != 0) begin
      n_errors = n_errors + 1;
      $display("unexpected stall at %0t", $time);
      exp_q.delete();
    end
  endtask
  task ev(input ext, input pu, input [3:0] ex, input drop);
    reg [30:0] st;
    reg [14:0] en;
    st = $random(seed);
    en = $random(seed);
    if (!drop) push_ev({ext, st}, {12'h0, ex, pmode & pu, (pmode | !pu) ? en : 15'h0});
    @(posedge clock);
    event_valid <= 1'b1; event_external <= ext; event_stamp <= st;
    event_energy <= en; event_pileup <= pu;
    @(posedge clock);
    event_valid <= 1'b0;
    drain;
  endtask
  task pulse_wrap;
    @(posedge clock) stamp_wrap <= 1'b1;
    @(posedge clock) stamp_wrap <= 1'b0;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    {rstn, write_strobe, read_strobe, event_valid, event_external, event_pileup} = 6'h0;
    {stamp_wrap, general_input_pin, saturated, memory_full, rd_pend, pmode} = 6'h0;
    {address, write_data, event_stamp, event_energy} = 86'h0;
    {seed, n_errors, samples_checked, cycles, didx, sidx} = {32'd75, 160'd0};
    slow = 1'b1;
    for (k = 0; k < 64; k = k + 1) smp[k] = $random(seed);
    nfmt = `RST_FORMAT;
    nevt = `RST_EVENTS;
    header;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(`OFFS_CONTROL, `RST_CONTROL);
    rd(`OFFS_FORMAT, `RST_FORMAT);
    rd(`OFFS_EVENTS, {22'h0, `RST_EVENTS});
    rd(`OFFS_DECAY, {16'h0, `RST_DECAY});
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0);
    for (k = 0; k < 10; k = k + 1) begin
      nfmt = 32'h7000_0000 | (k % 4) << 22 | ((k + 1) % 4) << 20 | k << 16;
      wr(`OFFS_FORMAT, nfmt);
      rd(`OFFS_FORMAT, nfmt);
    end
    nfmt = `RST_FORMAT;
    wr(`OFFS_FORMAT, nfmt);
    $display("registers done");
    ev(1'b1, 1'b1, 4'h0, 1'b0);
    slow = 1'b0;
    pulse_wrap;
    ev(1'b0, 1'b0, 4'b0010, 1'b0);
    @(posedge clock) memory_full <= 1'b1;
    ev(1'b0, 1'b0, 4'h0, 1'b1);
    @(posedge clock) memory_full <= 1'b0;
    ev(1'b0, 1'b0, 4'b0001, 1'b0);
    @(posedge clock) general_input_pin <= 1'b1;
    repeat (6) @(posedge clock);
    ev(1'b0, 1'b0, 4'b0100, 1'b0);
    @(posedge clock) general_input_pin <= 1'b0;
    wr(`OFFS_CONTROL, 32'h0600_0001);
    push_ev({1'b0, event_stamp}, {12'h0, 4'b1100, 16'h0});
    @(posedge clock) general_input_pin <= 1'b1;
    drain;
    push_ev({1'b0, event_stamp}, {12'h0, 4'b1010, 16'h0});
    pulse_wrap;
    drain;
    wr(`OFFS_CONTROL, `RST_CONTROL);
    $display("flags done");
    wr(`OFFS_DECAY, 32'h4);
    push_ev({1'b0, event_stamp}, 32'h0000_FFFF);
    @(posedge clock) saturated <= 1'b1;
    repeat (5) @(posedge clock);
    saturated <= 1'b0;
    ev(1'b0, 1'b0, 4'h0, 1'b1);
    repeat (12) @(posedge clock);
    ev(1'b0, 1'b0, 4'b0001, 1'b0);
    $display("saturation done");
    slow = 1'b1;
    nfmt = 32'hF099_0002;
    nevt = 10'd2;
    wr(`OFFS_FORMAT, nfmt);
    wr(`OFFS_EVENTS, {22'h0, nevt});
    wr(`OFFS_CONTROL, 32'h0800_0001);
    pmode = 1'b1;
    // The aggregate already announced keeps its old layout; the new one follows
    ev(1'b0, 1'b1, 4'h0, 1'b0);
    ev(1'b1, 1'b1, 4'h0, 1'b0);
    ev(1'b0, 1'b0, 4'h0, 1'b0);
    $display("waveform done");
    @(posedge clock) rstn <= 1'b0;
    repeat (3) @(posedge clock);
    exp_q.delete();
    nfmt = `RST_FORMAT;
    nevt = `RST_EVENTS;
    pmode = 1'b0;
    header;
    rstn <= 1'b1;
    drain;
    rd(`OFFS_CONTROL, `RST_CONTROL);
    $display("second reset done");
    results;
  end
endmodule
bind event_aggregate_formatter eaf_assertions i_eaf_assertions (.clock(clock), .rstn(rstn),
  .address(address), .read_strobe(read_strobe), .read_data(read_data),
  .saturated(saturated), .sample_valid(sample_valid), .sample_take(sample_take),
  .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready));

// >>> host_reader.sv
// Host readout model: accepts stream words, stalling when asked.
// Assumes one clock with the formatter.
`timescale 1ns/1ps
module host_reader (
  input  wire        clock,
  input  wire        rstn,
  input  wire [31:0] out_word,
  input  wire        out_valid,
  input  wire        slow,
  output reg         out_ready,
  output reg         got,
  output reg  [31:0] word
);
  reg [2:0] cnt;
  // Irregular stall pattern so holds are seen at several word positions
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt       <= 3'd0;
      out_ready <= 1'b0;
      got       <= 1'b0;
      word      <= 32'h0;
    end else begin
      cnt       <= cnt + 3'd1;
      out_ready <= !slow || (cnt[0] ^ cnt[2]);
      got       <= out_valid && out_ready;
      word      <= out_word;
    end
  end
endmodule

// >>> sticky_flag.v
// Single sticky flag set by hardware and cleared when an event takes it.
// Assumes both strobes come from the same clock domain.
`timescale 1ns/1ps
module sticky_flag (
  input  wire clock,
  input  wire rstn,
  input  wire set,
  input  wire clear,
  output reg  flag
);
  // Set beats clear so an event in the clearing cycle is not lost
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule
